// ### shared/ced_pkg.sv
// constants shared by the execute core and its arithmetic unit
// assumes one 200 MHz clock and a state time built from a clock divider
// Functional notes
// - word-immediate instructions take one state fewer than the baseline timing.
// - long-indexed instructions take one state fewer than the baseline timing.
// - block moves take fewer states than the baseline timing.
// - stack pointer is its own flop, usable as plain data storage.
// - auto-increment uses the old register value, increments at instruction end.
// - negating 8000h yields 8000h with negative and overflow flags set.
// - opcode EEh raises the unimplemented-opcode interrupt.
// - block moves take a long address pair register and 16-bit count.
// - block move counts only 0000h to 3FFFh are honoured.
// - multiply and divide finish in fewer states than the baseline.
package ced_pkg;
    localparam logic [7:0] OPC_NEG = 8'h03;
    localparam logic [7:0] OPC_ADDI = 8'h65;
    localparam logic [7:0] OPC_LDX = 8'hA3;
    localparam logic [7:0] OPC_STAI = 8'hC3;
    localparam logic [7:0] OPC_MUL = 8'h6C;
    localparam logic [7:0] OPC_DIV = 8'h8C;
    localparam logic [7:0] OPC_PUSH = 8'hC8;
    localparam logic [7:0] OPC_POP = 8'hCC;
    localparam logic [7:0] OPC_BLKMOVE = 8'hC1;
    localparam logic [7:0] OPC_BLKMOVE_INT = 8'hCD;
    localparam logic [7:0] OPC_TRAP = 8'hEE;
    localparam logic [7:0] SP_ADDR = 8'h18;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [7:0] PAIR_STEP = 8'h02;
    localparam logic [13:0] BM_COUNT_MASK = 14'h3FFF;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam int FLAG_N = 3;
    localparam int FLAG_V = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam int STATE_CLKS = 2;
    localparam logic [5:0] BASE_ALU = 6'd4;
    localparam logic [5:0] BASE_ADDI = 6'd5;
    localparam logic [5:0] BASE_LDX = 6'd8;
    localparam logic [5:0] BASE_STK = 6'd8;
    localparam logic [5:0] BASE_BLKMOVE = 6'd8;
    localparam logic [5:0] BASE_MUL = 6'd16;
    localparam logic [5:0] BASE_DIV = 6'd24;
    localparam logic [5:0] ST_ADDI = BASE_ADDI - 6'd1;
    localparam logic [5:0] ST_LDX = BASE_LDX - 6'd1;
    localparam logic [5:0] ST_BLKMOVE = BASE_BLKMOVE - 6'd2;
    localparam logic [5:0] ST_MUL = BASE_MUL - 6'd4;
    localparam logic [5:0] ST_DIV = BASE_DIV - 6'd6;
    typedef enum logic [2:0] {
        CED_ALU_NONE = 3'h0,
        CED_ALU_NEG = 3'h1,
        CED_ALU_ADD = 3'h2,
        CED_ALU_MUL = 3'h3,
        CED_ALU_DIV = 3'h4
    } ced_alu_t;
endpackage

// ### logic/ced_alu.sv
// word arithmetic unit: negate, add, multiply and divide in one cycle
// assumes the caller picks the operation and latches the results
`timescale 1ns/1ps
`default_nettype none
module ced_alu
    import ced_pkg::*;
(
    // operation
    input wire ced_alu_t op_i,
    // operands
    input wire logic [15:0] a_lo_i,
    input wire logic [15:0] a_hi_i,
    input wire logic [15:0] b_i,
    // results
    output logic [15:0] res_lo_o,
    output logic [15:0] res_hi_o,
    output logic [3:0] flags_o
);
    wire [16:0] neg_full = 17'h00000 - {1'b0, a_lo_i};
    wire [16:0] add_full = {1'b0, a_lo_i} + {1'b0, b_i};
    wire [31:0] product = {16'h0000, a_lo_i} * {16'h0000, b_i};
    wire [31:0] dividend = {a_hi_i, a_lo_i};
    wire div_zero = (b_i == 16'h0000);
    wire [31:0] quot_full = div_zero ? 32'hFFFFFFFF : dividend / {16'h0000, b_i};
    wire [31:0] rem_full = div_zero ? dividend : dividend % {16'h0000, b_i};
    // overflow of negate only for the most negative word, whose sign stays set
    wire neg_v = (a_lo_i == 16'h8000);
    wire add_v = (a_lo_i[15] == b_i[15]) && (add_full[15] != a_lo_i[15]);
    wire div_v = div_zero || (quot_full[31:16] != 16'h0000);

    always_comb begin
        res_lo_o = a_lo_i;
        res_hi_o = a_hi_i;
        flags_o = FLAGS_RESET;
        unique case (op_i)
            CED_ALU_NEG: begin
                res_lo_o = neg_full[15:0];
                flags_o[FLAG_N] = neg_full[15];
                flags_o[FLAG_V] = neg_v;
                flags_o[FLAG_C] = ~neg_full[16];
            end
            CED_ALU_ADD: begin
                res_lo_o = add_full[15:0];
                flags_o[FLAG_N] = add_full[15];
                flags_o[FLAG_V] = add_v;
                flags_o[FLAG_C] = add_full[16];
            end
            CED_ALU_MUL: begin
                res_lo_o = product[15:0];
                res_hi_o = product[31:16];
                flags_o[FLAG_N] = product[31];
            end
            CED_ALU_DIV: begin
                res_lo_o = quot_full[15:0];
                res_hi_o = rem_full[15:0];
                flags_o[FLAG_V] = div_v;
            end
            CED_ALU_NONE: begin
                res_lo_o = a_lo_i;
            end
        endcase
        flags_o[FLAG_Z] = (res_lo_o == 16'h0000);
    end
endmodule // ced_alu
`default_nettype wire

// ### logic/ced_core.sv
// execute core: takes one decoded instruction at a time, owns register RAM
// assumes instructions arrive already fetched and memory answers with an ack
`timescale 1ns/1ps
`default_nettype none
module ced_core
    import ced_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // instruction in
    input wire logic instr_valid_i,
    input wire logic [7:0] instr_opcode_i,
    input wire logic [7:0] instr_op_a_i,
    input wire logic [7:0] instr_op_b_i,
    input wire logic [15:0] instr_imm_i,
    output logic instr_ready_o,
    // data memory
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // events and status
    input wire logic irq_pending_i,
    output logic unimpl_irq_o,
    output logic done_o,
    output logic [3:0] flags_o,
    output logic [15:0] stack_pointer_reg_o
);
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_EXEC = 9'h002,
        S_MEMRD = 9'h004,
        S_MEMWR = 9'h008,
        S_BMRD = 9'h010,
        S_BMWR = 9'h020,
        S_BMEND = 9'h040,
        S_FINISH = 9'h080,
        S_WAIT = 9'h100
    } ced_state_t;

    ced_state_t state;
    logic [7:0] op;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [15:0] imm;
    logic [15:0] regs [0:127];
    logic [15:0] stack_pointer_reg;
    logic [15:0] bm_src;
    logic [15:0] bm_dst;
    logic [13:0] bm_cnt;
    logic [15:0] bm_data;
    logic [5:0] budget;
    logic [5:0] elapsed;
    logic [1:0] div_cnt;
    logic state_tick;
    logic wr1_en;
    logic [7:0] wr1_addr;
    logic [15:0] wr1_data;
    logic wr2_en;
    logic [7:0] wr2_addr;
    logic [15:0] wr2_data;

    // register reads; the stack pointer answers at its own address
    wire [7:0] op_a_hi = op_a + PAIR_STEP;
    wire [15:0] rd_a = (op_a == SP_ADDR) ? stack_pointer_reg : regs[op_a[7:1]];
    wire [15:0] rd_a_hi = (op_a_hi == SP_ADDR) ? stack_pointer_reg
                                               : regs[op_a_hi[7:1]];
    wire [15:0] rd_b = (op_b == SP_ADDR) ? stack_pointer_reg : regs[op_b[7:1]];

    // opcode decode
    wire is_neg = (op == OPC_NEG);
    wire is_addi = (op == OPC_ADDI);
    wire is_ldx = (op == OPC_LDX);
    wire is_stai = (op == OPC_STAI);
    wire is_mul = (op == OPC_MUL);
    wire is_div = (op == OPC_DIV);
    wire is_push = (op == OPC_PUSH);
    wire is_pop = (op == OPC_POP);
    wire is_blk_int = (op == OPC_BLKMOVE_INT);
    wire is_bm = (op == OPC_BLKMOVE) || is_blk_int;
    wire is_trap = (op == OPC_TRAP);
    wire is_alu = is_neg || is_addi || is_mul || is_div;

    wire ced_alu_t alu_op = is_neg ? CED_ALU_NEG : is_addi ? CED_ALU_ADD :
                            is_mul ? CED_ALU_MUL : is_div ? CED_ALU_DIV :
                            CED_ALU_NONE;
    wire [15:0] alu_b = is_addi ? imm : rd_b;
    wire [15:0] alu_lo;
    wire [15:0] alu_hi;
    wire [3:0] alu_flags;

    ced_alu u_alu (
        .op_i(alu_op),
        .a_lo_i(rd_a),
        .a_hi_i(rd_a_hi),
        .b_i(alu_b),
        .res_lo_o(alu_lo),
        .res_hi_o(alu_hi),
        .flags_o(alu_flags)
    );

    // state budgets; reduced counts for word-immediate, long-indexed, block move, multiply and divide, baseline counts for the rest
    wire [5:0] next_budget = is_addi ? ST_ADDI :
                             is_ldx ? ST_LDX :
                             is_bm ? ST_BLKMOVE :
                             is_mul ? ST_MUL :
                             is_div ? ST_DIV :
                             (is_push || is_pop || is_stai) ? BASE_STK :
                             BASE_ALU;

    // hardware counter is 14 bits wide, so the top two count bits are dropped
    wire [13:0] next_bm_cnt = rd_b[13:0] & BM_COUNT_MASK;
    wire bm_last = (bm_cnt == 14'h0001) || (is_blk_int && irq_pending_i);
    wire accept = instr_valid_i && instr_ready_o;

    // register file write ports
    always_comb begin
        wr1_en = 1'b0;
        wr1_addr = op_a;
        wr1_data = alu_lo;
        wr2_en = 1'b0;
        wr2_addr = op_a_hi;
        wr2_data = alu_hi;
        if (state == S_EXEC && is_alu) begin
            wr1_en = 1'b1;
            wr2_en = is_mul || is_div;
        end else if (state == S_EXEC && is_push) begin
            wr1_en = 1'b1;
            wr1_addr = SP_ADDR;
            wr1_data = stack_pointer_reg - WORD_STEP;
        end else if (state == S_MEMRD && mem_ack_i && (is_ldx || is_pop)) begin
            wr1_en = 1'b1;
            wr1_data = mem_rdata_i;
        end else if (state == S_BMEND) begin
            wr1_en = 1'b1;
            wr1_data = bm_src;
            wr2_en = 1'b1;
            wr2_data = bm_dst;
        end else if (state == S_FINISH) begin
            wr1_en = is_stai || is_pop || is_bm;
            wr1_addr = is_pop ? SP_ADDR : op_b;
            wr1_data = is_bm ? {2'b00, bm_cnt} :
                       is_pop ? stack_pointer_reg + WORD_STEP :
                       rd_b + WORD_STEP;
        end
    end

    // the pointer lives in a flop, not in the RAM array
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stack_pointer_reg <= SP_RESET;
        end else if (wr1_en && wr1_addr == SP_ADDR) begin
            stack_pointer_reg <= wr1_data;
        end else if (wr2_en && wr2_addr == SP_ADDR) begin
            stack_pointer_reg <= wr2_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr1_en && wr1_addr != SP_ADDR) begin
            regs[wr1_addr[7:1]] <= wr1_data;
        end
        if (wr2_en && wr2_addr != SP_ADDR) begin
            regs[wr2_addr[7:1]] <= wr2_data;
        end
    end

    // state time enable
    always_ff @(posedge clk_i) begin
        if (rst_i || div_cnt == 2'(STATE_CLKS - 1)) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
        state_tick <= !rst_i && div_cnt == 2'(STATE_CLKS - 1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || accept) begin
            elapsed <= 6'h00;
        end else if (state_tick && state != S_IDLE && elapsed != 6'h3F) begin
            elapsed <= elapsed + 6'h01;
        end
    end

    assign stack_pointer_reg_o = stack_pointer_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            instr_ready_o <= 1'b1;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 16'h0000;
            unimpl_irq_o <= 1'b0;
            done_o <= 1'b0;
            flags_o <= FLAGS_RESET;
            op <= 8'h00;
            op_a <= 8'h00;
            op_b <= 8'h00;
            imm <= 16'h0000;
            bm_src <= 16'h0000;
            bm_dst <= 16'h0000;
            bm_cnt <= 14'h0000;
            bm_data <= 16'h0000;
            budget <= BASE_ALU;
        end else begin
            unimpl_irq_o <= 1'b0;
            done_o <= 1'b0;
            unique case (state)
                S_IDLE: if (accept) begin
                    op <= instr_opcode_i;
                    op_a <= instr_op_a_i;
                    op_b <= instr_op_b_i;
                    imm <= instr_imm_i;
                    instr_ready_o <= 1'b0;
                    state <= S_EXEC;
                end
                S_EXEC: begin
                    budget <= next_budget;
                    state <= S_WAIT;
                    if (is_trap) begin
                        unimpl_irq_o <= 1'b1;
                    end else if (is_alu) begin
                        flags_o <= alu_flags;
                    end else if (is_ldx || is_pop) begin
                        mem_req_o <= 1'b1;
                        mem_addr_o <= is_pop ? stack_pointer_reg
                                             : rd_b + imm;
                        state <= S_MEMRD;
                    end else if (is_stai || is_push) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= is_push ? stack_pointer_reg - WORD_STEP
                                              : rd_b;
                        mem_wdata_o <= rd_a;
                        state <= S_MEMWR;
                    end else if (is_bm) begin
                        bm_src <= rd_a;
                        bm_dst <= rd_a_hi;
                        bm_cnt <= next_bm_cnt;
                        state <= (next_bm_cnt == 14'h0000) ? S_BMEND : S_BMRD;
                    end
                end
                S_MEMRD: if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    state <= is_pop ? S_FINISH : S_WAIT;
                end
                S_MEMWR: if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    state <= is_stai ? S_FINISH : S_WAIT;
                end
                S_BMRD: begin
                    mem_req_o <= !mem_ack_i;
                    mem_addr_o <= bm_src;
                    if (mem_req_o && mem_ack_i) begin
                        bm_data <= mem_rdata_i;
                        state <= S_BMWR;
                    end
                end
                S_BMWR: begin
                    mem_req_o <= !mem_ack_i;
                    mem_we_o <= !mem_ack_i;
                    mem_addr_o <= bm_dst;
                    mem_wdata_o <= bm_data;
                    if (mem_req_o && mem_ack_i) begin
                        bm_src <= bm_src + WORD_STEP;
                        bm_dst <= bm_dst + WORD_STEP;
                        bm_cnt <= bm_cnt - 14'h0001;
                        // interruptible form stops here; software re-issues it
                        state <= bm_last ? S_BMEND : S_BMRD;
                    end
                end
                S_BMEND: state <= S_FINISH;
                S_FINISH: state <= S_WAIT;
                S_WAIT: if (elapsed >= budget) begin
                    done_o <= 1'b1;
                    instr_ready_o <= 1'b1;
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // ced_core
`default_nettype wire

// ### verification/ced_core_props.sv
// checker for the execute core: handshake, pulses and state budgets
// assumes it is bound onto every ced_core instance
`timescale 1ns/1ps
`default_nettype none
module ced_core_props
    import ced_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic instr_valid_i,
    input wire logic [7:0] instr_opcode_i,
    input wire logic instr_ready_o,
    input wire logic mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic [15:0] mem_wdata_o,
    input wire logic unimpl_irq_o,
    input wire logic done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take(logic [7:0] op);
        instr_valid_i && instr_ready_o && instr_opcode_i == op;
    endsequence
    a_take_busy: assert property (
        instr_valid_i && instr_ready_o |=> !instr_ready_o)
        else $error("ready stayed high after accept");
    a_done_ready: assert property (
        done_o |-> instr_ready_o ##1 !done_o)
        else $error("done pulse malformed");
    a_trap_irq: assert property (
        s_take(OPC_TRAP) |-> ##[1:40] unimpl_irq_o)
        else $error("reserved opcode did not trap");
    a_irq_pulse: assert property (
        unimpl_irq_o |=> !unimpl_irq_o)
        else $error("trap pulse too long");
    a_addi_fast: assert property (
        s_take(OPC_ADDI) |-> ##[1:10] done_o)
        else $error("word immediate too slow");
    a_ldx_fast: assert property (
        s_take(OPC_LDX) |-> ##[1:16] done_o)
        else $error("long indexed too slow");
    a_mul_fast: assert property (
        s_take(OPC_MUL) |-> ##[1:31] done_o)
        else $error("multiply too slow");
    a_div_fast: assert property (
        s_take(OPC_DIV) |-> ##[1:47] done_o)
        else $error("divide too slow");
    a_mem_hold: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
            && $stable(mem_wdata_o))
        else $error("memory request changed before ack");
endmodule // ced_core_props
bind ced_core ced_core_props u_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .instr_valid_i(instr_valid_i),
    .instr_opcode_i(instr_opcode_i),
    .instr_ready_o(instr_ready_o),
    .mem_req_o(mem_req_o),
    .mem_ack_i(mem_ack_i),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .unimpl_irq_o(unimpl_irq_o),
    .done_o(done_o)
);
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the execute core with a register file model
// assumes registers are loaded by pop and observed by store-increment
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ced_pkg::*;
    logic clk_i, rst_i, instr_valid_i, mem_ack_i, irq_pending_i, ui;
    logic [7:0] instr_opcode_i, instr_op_a_i, instr_op_b_i;
    logic [15:0] instr_imm_i, mem_rdata_i, mem_addr_o, mem_wdata_o;
    logic instr_ready_o, mem_req_o, mem_we_o, unimpl_irq_o, done_o;
    logic [15:0] stack_pointer_reg_o, d, x, y;
    logic [3:0] flags_o, mf;
    logic [31:0] p;
    logic [15:0] rf [256];
    logic [15:0] mem [logic [15:0]];
    logic [32:0] q [$];
    logic [15:0] nv [5] = '{16'h8000, 16'h0000, 16'h0001, 16'h7FFF, 16'hFFFF};
    int n_fail = 0, n_tests = 0, cyc = 0, wt = 0, lat;
    ced_core uut (
        .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_opcode_i(instr_opcode_i), .instr_op_a_i(instr_op_a_i),
        .instr_op_b_i(instr_op_b_i), .instr_imm_i(instr_imm_i),
        .instr_ready_o(instr_ready_o), .mem_req_o(mem_req_o),
        .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .irq_pending_i(irq_pending_i),
        .unimpl_irq_o(unimpl_irq_o), .done_o(done_o), .flags_o(flags_o),
        .stack_pointer_reg_o(stack_pointer_reg_o)
    );
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    function automatic logic [15:0] rdm(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : ~a;
    endfunction
    function automatic logic [32:0] pop();
        return q.size() != 0 ? q.pop_front() : {33{1'bx}};
    endfunction
    // memory answers after 0..2 idle cycles; idle data keeps toggling
    always @(negedge clk_i) begin
        if (mem_req_o === 1'b1 && !mem_ack_i && wt == 0) begin
            mem_ack_i <= 1'b1;
            mem_rdata_i <= rdm(mem_addr_o);
            wt <= $urandom % 3;
        end else begin
            if (mem_req_o === 1'b1 && !mem_ack_i) wt <= wt - 1;
            mem_ack_i <= 1'b0;
            mem_rdata_i <= ~mem_rdata_i;
        end
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (mem_req_o && mem_ack_i) begin
            q.push_back({mem_we_o, mem_addr_o,
                mem_we_o ? mem_wdata_o : mem_rdata_i});
            if (mem_we_o) mem[mem_addr_o] = mem_wdata_o;
        end
        if (cyc == 20000) begin
            n_fail++;
            end_sim;
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_lat(input int lo, input int hi);
        n_tests++;
        if (lat < lo || lat > hi) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h max=%h", $time, lat, hi);
        end
    endtask
    task automatic run(input logic [7:0] o, a, b, input logic [15:0] im);
        @(negedge clk_i);
        instr_valid_i = 1'b1;
        instr_opcode_i = o;
        instr_op_a_i = a;
        instr_op_b_i = b;
        instr_imm_i = im;
        lat = 0;
        ui = 1'b0;
        do begin
            @(negedge clk_i);
            instr_valid_i = 1'b0;
            lat++;
            ui = ui | unimpl_irq_o;
        end while (done_o !== 1'b1 && lat < 2000);
        chk(done_o, 1'b1);
    endtask
    task automatic ld(input logic [7:0] a, input logic [15:0] v);
        mem[rf[SP_ADDR]] = v;
        run(OPC_POP, a, 8'h00, 16'h0000);
        chk(pop(), {1'b0, rf[SP_ADDR], v});
        rf[a] = v;
        rf[SP_ADDR] += WORD_STEP;
        chk(stack_pointer_reg_o, rf[SP_ADDR]);
    endtask
    task automatic st(input logic [7:0] a);
        run(OPC_STAI, a, 8'h40, 16'h0000);
        chk(pop(), {1'b1, rf[8'h40], rf[a]});
        rf[8'h40] += WORD_STEP;
    endtask
    task automatic addi(input logic [7:0] a, input logic [15:0] im);
        logic [16:0] s;
        s = rf[a] + im;
        mf = {s[15], rf[a][15] == im[15] && s[15] != rf[a][15],
            s[15:0] == 16'h0000, s[16]};
        rf[a] = s[15:0];
        run(OPC_ADDI, a, 8'h00, im);
        chk_lat(ST_ADDI * STATE_CLKS - 1, BASE_ADDI * STATE_CLKS);
        chk(flags_o, mf);
    endtask
    initial begin
        rst_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_opcode_i = 8'h00;
        instr_op_a_i = 8'h00;
        instr_op_b_i = 8'h00;
        instr_imm_i = 16'h0000;
        mem_ack_i = 1'b0;
        mem_rdata_i = 16'h0000;
        irq_pending_i = 1'b0;
        void'($urandom(32'h1791923D));
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk(instr_ready_o, 1'b1);
        chk(stack_pointer_reg_o, SP_RESET);
        chk(flags_o, FLAGS_RESET);
        rst_i = 1'b0;
        rf[SP_ADDR] = SP_RESET;
        ld(8'h40, 16'h2000);
        addi(SP_ADDR, 16'h0100);
        chk(stack_pointer_reg_o, rf[SP_ADDR]);
        run(OPC_PUSH, 8'h40, 8'h00, 16'h0000);
        rf[SP_ADDR] -= WORD_STEP;
        chk(pop(), {1'b1, rf[SP_ADDR], rf[8'h40]});
        chk(stack_pointer_reg_o, rf[SP_ADDR]);
        for (int i = 0; i < 8; i++) begin
            ld(8'h50, i == 0 ? 16'h7FFF : i == 1 ? 16'hFFFF : 16'($urandom));
            addi(8'h50, i < 2 ? 16'h0001 : 16'($urandom));
            st(8'h50);
        end
        foreach (nv[i]) begin
            ld(8'h52, nv[i]);
            mf = {nv[i] != 16'h0000 && nv[i] <= 16'h8000, nv[i] == 16'h8000,
                nv[i] == 16'h0000, nv[i] == 16'h0000};
            rf[8'h52] = -nv[i];
            run(OPC_NEG, 8'h52, 8'h00, 16'h0000);
            chk(flags_o, mf);
            st(8'h52);
        end
        st(8'h40);
        st(8'h52);
        run(OPC_TRAP, 8'h00, 8'h00, 16'h0000);
        chk(ui, 1'b1);
        run(8'hEF, 8'h00, 8'h00, 16'h0000);
        chk(ui, 1'b0);
        ld(8'h60, 16'h3000);
        d = rdm(16'h3010);
        run(OPC_LDX, 8'h54, 8'h60, 16'h0010);
        chk_lat(ST_LDX * STATE_CLKS - 1, BASE_LDX * STATE_CLKS);
        chk(pop(), {1'b0, 16'h3010, d});
        rf[8'h54] = d;
        st(8'h54);
        x = 16'($urandom) & 16'h7FFF;
        y = (16'($urandom) & 16'h7FFF) | 16'h0001;
        ld(8'h56, x);
        ld(8'h5A, y);
        run(OPC_MUL, 8'h56, 8'h5A, 16'h0000);
        chk_lat(ST_MUL * STATE_CLKS - 1, BASE_MUL * STATE_CLKS);
        p = x * y;
        {rf[8'h58], rf[8'h56]} = p;
        y = y | 16'h4000;
        ld(8'h5A, y);
        run(OPC_DIV, 8'h56, 8'h5A, 16'h0000);
        chk_lat(ST_DIV * STATE_CLKS - 1, BASE_DIV * STATE_CLKS);
        rf[8'h56] = 16'(p / y);
        rf[8'h58] = 16'(p % y);
        st(8'h56);
        st(8'h58);
        ld(8'h70, 16'h4000);
        ld(8'h72, 16'h5000);
        ld(8'h74, 16'hC003);
        run(OPC_BLKMOVE, 8'h70, 8'h74, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            d = rdm(16'h4000 + 16'(2 * i));
            chk(pop(), {1'b0, 16'h4000 + 16'(2 * i), d});
            chk(pop(), {1'b1, 16'h5000 + 16'(2 * i), d});
        end
        chk(33'(q.size()), 33'h0);
        rf[8'h70] = 16'h4006;
        rf[8'h72] = 16'h5006;
        rf[8'h74] = 16'h0000;
        st(8'h70);
        st(8'h72);
        st(8'h74);
        // empty count with a pending interrupt: nothing may move
        irq_pending_i = 1'b1;
        run(OPC_BLKMOVE_INT, 8'h70, 8'h74, 16'h0000);
        irq_pending_i = 1'b0;
        chk_lat(ST_BLKMOVE * STATE_CLKS - 1,
            BASE_BLKMOVE * STATE_CLKS);
        chk(33'(q.size()), 33'h0);
        // two words asked with an interrupt pending: only the first moves
        ld(8'h74, 16'h0002);
        d = rdm(16'h4006);
        irq_pending_i = 1'b1;
        run(OPC_BLKMOVE_INT, 8'h70, 8'h74, 16'h0000);
        irq_pending_i = 1'b0;
        chk(pop(), {1'b0, 16'h4006, d});
        chk(pop(), {1'b1, 16'h5006, d});
        chk(33'(q.size()), 33'h0);
        rf[8'h70] = 16'h4008;
        rf[8'h72] = 16'h5008;
        rf[8'h74] = 16'h0001;
        st(8'h70);
        st(8'h72);
        st(8'h74);
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
